// *** ftf_blink.sv ***
// Blink generator for the I/O-enabled indicator.
`timescale 1ns/1ps
module ftf_blink import ftf_pkg::*; #(
    parameter int unsigned HALF_CYC = BLINK_CYC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control and indicator
    input wire logic active,
    output logic led_q
);
    logic [31:0] cnt_q;
    logic ph_q;
    logic tick;

    assign tick = (cnt_q == 32'(HALF_CYC - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn || !active) begin
            cnt_q <= 32'h0000_0000;
        end else if (tick) begin
            cnt_q <= 32'h0000_0000;
        end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !active) begin
            ph_q <= 1'b1;
        end else if (tick) begin
            ph_q <= ~ph_q;
        end
    end

    // Steady on when nothing is forced, blinking otherwise.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            led_q <= 1'b1;
        end else begin
            led_q <= active ? ph_q : 1'b1;
        end
    end
endmodule

// *** ftf_host.sv ***
// Host controller model that drives clears and point outputs.
`timescale 1ns/1ps
module ftf_host import ftf_pkg::*; (
    // Clock, reset and bench command
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clr_cmd,
    // Toward the unit
    output logic host_clear,
    output logic host_out_valid,
    output logic [PTS-1:0][15:0] host_out
);
    // A clear of the host table goes out as one broadcast pulse.
    always_ff @(posedge aclk) begin
        host_clear <= aresetn && clr_cmd;
        host_out_valid <= aresetn;
    end
    for (genvar p = 0; p < PTS; p++) begin : g_out
        assign host_out[p] = 16'h5A00 + 16'(p);
    end
endmodule

// *** ftf_pkg.sv ***
// Constants and types shared by the fault table and force control block.
package ftf_pkg;
    // ------------------------------------------------------------------
    // Table sizes
    // ------------------------------------------------------------------
    localparam int FIX_N = 16;
    localparam int FIFO_N = 16;
    localparam int TOT_N = 32;
    localparam int PTS = 16;
    localparam int DIAG_N = 6;

    // ------------------------------------------------------------------
    // Register byte offsets and response codes
    // ------------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_SEL = 8'h08;
    localparam logic [7:0] A_FDATA = 8'h0C;
    localparam logic [7:0] A_FCMD = 8'h10;
    localparam logic [7:0] A_MAP = 8'h14;
    localparam logic [7:0] A_HOLD = 8'h18;
    localparam logic [7:0] A_FMASK = 8'h1C;
    localparam logic [1:0] RSP_OK = 2'h0;
    localparam logic [1:0] RSP_ERR = 2'h2;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_CLR = 0;
    localparam int ST_EMPTY = 16;
    localparam int ST_FORCED = 17;
    localparam int ST_REJ = 18;
    localparam int ST_SEEN = 19;
    localparam int FD_PRES = 16;
    localparam int FC_IDX = 16;
    localparam int FC_SLOT = 20;
    localparam int FC_UNF = 24;
    localparam logic [4:0] MAP_RST = 5'h10;
    localparam logic [15:0] HOLD_RST = 16'h0000;

    // ------------------------------------------------------------------
    // Fault classes and self-diagnostic codes
    // ------------------------------------------------------------------
    localparam logic [1:0] CLS_UNIT = 2'h0;
    localparam logic [1:0] CLS_MODULE = 2'h1;
    localparam logic [1:0] CLS_CIRCUIT = 2'h2;
    localparam logic [1:0] CLS_SELF = 2'h3;
    localparam logic [2:0] SELF_SLOT = 3'h0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int BLINK_MS = 250;
    localparam int BLINK_CYC = BLINK_MS * CLK_MHZ * 1000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] cls;
        logic [2:0] slot;
        logic [4:0] circ;
        logic [3:0] code;
    } ftf_fault_t;

    typedef struct packed {
        logic valid;
        logic unforce;
        logic [3:0] idx;
        logic [2:0] slot;
        logic [15:0] value;
    } ftf_force_req_t;

    typedef struct packed {
        logic on;
        logic [2:0] slot;
        logic [15:0] value;
    } ftf_force_ent_t;

    typedef enum logic [1:0] {
        ST_LOAD = 2'b01,
        ST_RUN = 2'b10
    } ftf_state_t;
endpackage

// *** ftf_top.sv ***
// Fault table and I/O force control of the station interface unit.
//
// Functional notes
// RULE1 - The table holds at most 32 uncleared faults.
// RULE2 - Module faults and own diagnostics enter the same table.
// RULE3 - The first 16 faults since a clear stay until the next clear.
// RULE4 - Faults 17 to 32 form a queue; a 33rd drops the oldest.
// RULE5 - Each entry carries its class: unit, module or circuit level.
// RULE6 - Own diagnostics (address, comms, controllers, memories, processor) are reported.
// RULE7 - Entries are read one at a time as first 16 and last 16.
// RULE8 - The host controller broadcasts clear-all-circuit-faults when its table clears.
// RULE9 - A clear removes entries only; a persisting condition is recorded again.
// RULE10 - A clear before first host outputs may lose module lost or extra faults.
// RULE11 - An older host zeroes its fault count and sends a clear command.
// RULE12 - Forced state comes from nonvolatile storage and survives power cycles.
// RULE13 - A forced circuit ignores field inputs and host outputs.
// RULE14 - Forces outside the configured I/O map are rejected.
// RULE15 - Force and unforce come from the handheld terminal or bus datagrams.
// RULE16 - The I/O-enabled indicator blinks while any circuit is forced.
// RULE17 - After unforce outputs follow the host, else default or hold.
// RULE18 - Deleting a module discards its forces; only other removal is unforce.
// RULE19 - A force overrides default-to-zero and hold-last-state.
// RULE20 - A hold-last-state circuit forced online keeps the forced state as last.
`timescale 1ns/1ps
module ftf_top import ftf_pkg::*; #(
    parameter int unsigned BLINK_HALF = BLINK_CYC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Fault sources and clear commands
    input wire logic flt_valid,
    input wire ftf_fault_t flt_data,
    output logic flt_ready,
    input wire logic [DIAG_N-1:0] diag_lvl,
    input wire logic host_clear,
    input wire logic handheld_terminal_clear,
    // Force requests and configuration
    input wire ftf_force_req_t handheld_terminal_req,
    input wire logic cfg_del_valid,
    input wire logic [2:0] cfg_del_slot,
    // Nonvolatile force image
    input wire ftf_force_ent_t [PTS-1:0] nv_image_i,
    output ftf_force_ent_t [PTS-1:0] nv_image_o,
    output logic nv_save,
    // Point data
    input wire logic host_out_valid,
    input wire logic [PTS-1:0][15:0] host_out,
    input wire logic [PTS-1:0][15:0] field_in,
    output logic [PTS-1:0][15:0] pt_out,
    output logic [PTS-1:0][15:0] pt_in,
    output logic led_io_en
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    ftf_state_t st_q;
    ftf_force_ent_t [PTS-1:0] frc_q;
    logic [13:0] fix_q [FIX_N];
    logic [13:0] ff_q [FIFO_N];
    logic [4:0] fix_cnt_q, ff_cnt_q;
    logic [3:0] ff_wp_q, ff_old;
    logic [DIAG_N-1:0] diag_prev_q, diag_pend_q, diag_pick;
    logic host_seen_q, rej_q, clr_sw_q, nv_save_q;
    logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [4:0] sel_q, map_q;
    logic [15:0] hold_q, fmask;
    ftf_force_req_t bus_req_q, req;
    logic clr, ins, ins_diag, wr_go, bus_take, req_ok, rej_evt, any_forced;
    ftf_fault_t ins_ent;
    logic [13:0] rd_ent;
    logic rd_pres;
    logic [PTS-1:0][15:0] last_q, pt_out_q, pt_in_q;

    function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = n[8*b +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Start-up: restore forces from nonvolatile storage
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= ST_LOAD;
        end else begin
            case (st_q)
                ST_LOAD: st_q <= ST_RUN;
                ST_RUN: st_q <= ST_RUN;
                default: st_q <= ST_LOAD;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Fault table insertion and clear
    // ------------------------------------------------------------------
    // Any of the three clear sources empties the table; a clear before the first host
    // outputs therefore also drops module lost or extra faults seen so far (see RULE10).
    assign clr = host_clear | handheld_terminal_clear | clr_sw_q; // see RULE8 see RULE11
    // A fault offered during a clear waits until the clear ends instead of vanishing with the table.
    assign flt_ready = (st_q == ST_RUN) && !clr;
    assign diag_pick = diag_pend_q & (~diag_pend_q + DIAG_N'(1));
    assign ins_diag = !flt_valid && (diag_pend_q != '0) && (st_q == ST_RUN) && !clr;
    assign ins = (flt_valid && flt_ready) || ins_diag; // see RULE2

    always_comb begin
        ins_ent = flt_data; // see RULE5
        if (!flt_valid) begin
            ins_ent.cls = CLS_SELF; // see RULE6
            ins_ent.slot = SELF_SLOT;
            ins_ent.circ = 5'h00;
            ins_ent.code = 4'h0;
            for (int k = 0; k < DIAG_N; k++) begin
                if (diag_pick[k]) begin
                    ins_ent.code = 4'(k);
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || clr) begin
            fix_cnt_q <= 5'h00; // see RULE9
            ff_cnt_q <= 5'h00;
            ff_wp_q <= 4'h0;
        end else if (ins) begin
            if (fix_cnt_q < 5'(FIX_N)) begin
                fix_q[fix_cnt_q[3:0]] <= ins_ent; // see RULE3
                fix_cnt_q <= fix_cnt_q + 5'h01;
            end else begin
                ff_q[ff_wp_q] <= ins_ent; // see RULE4
                ff_wp_q <= ff_wp_q + 4'h1;
                if (ff_cnt_q < 5'(FIFO_N)) begin
                    ff_cnt_q <= ff_cnt_q + 5'h01; // see RULE1
                end
            end
        end
    end

    // Edge-detected diagnostics; a clear re-arms every condition still present.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            diag_prev_q <= '0;
            diag_pend_q <= '0;
        end else if (clr) begin
            diag_prev_q <= diag_lvl;
            diag_pend_q <= diag_lvl; // see RULE9
        end else begin
            diag_prev_q <= diag_lvl;
            diag_pend_q <= (diag_pend_q & ~(ins_diag ? diag_pick : '0)) | (diag_lvl & ~diag_prev_q);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            host_seen_q <= 1'b0;
        end else if (host_out_valid) begin
            host_seen_q <= 1'b1;
        end
    end

    // Read side: set 0 is the fixed part, set 1 the queue from its oldest entry.
    assign ff_old = ff_wp_q - ff_cnt_q[3:0];
    always_comb begin
        if (sel_q[4]) begin
            rd_pres = {1'b0, sel_q[3:0]} < ff_cnt_q; // see RULE7
            rd_ent = ff_q[ff_old + sel_q[3:0]];
        end else begin
            rd_pres = {1'b0, sel_q[3:0]} < fix_cnt_q;
            rd_ent = fix_q[sel_q[3:0]];
        end
    end

    // ------------------------------------------------------------------
    // Force table
    // ------------------------------------------------------------------
    // The handheld terminal wins a tie; a bus request simply waits until the handheld request drops.
    assign bus_take = bus_req_q.valid && !handheld_terminal_req.valid && (st_q == ST_RUN);
    assign req = handheld_terminal_req.valid ? handheld_terminal_req : bus_req_q; // see RULE15
    assign req_ok = {1'b0, req.idx} < map_q; // see RULE14
    assign rej_evt = req.valid && (st_q == ST_RUN) && !req_ok;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frc_q <= '0;
            nv_save_q <= 1'b0;
        end else if (st_q == ST_LOAD) begin
            frc_q <= nv_image_i; // see RULE12
            nv_save_q <= 1'b0;
        end else begin
            nv_save_q <= 1'b0;
            if (req.valid && req_ok) begin
                frc_q[req.idx].on <= !req.unforce; // see RULE17
                frc_q[req.idx].slot <= req.slot;
                frc_q[req.idx].value <= req.value;
                nv_save_q <= 1'b1;
            end
            if (cfg_del_valid) begin
                for (int i = 0; i < PTS; i++) begin
                    if (frc_q[i].slot == cfg_del_slot) begin
                        frc_q[i].on <= 1'b0; // see RULE18
                    end
                end
                nv_save_q <= 1'b1;
            end
        end
    end
    assign nv_image_o = frc_q;
    assign nv_save = nv_save_q;

    // ------------------------------------------------------------------
    // Point data paths
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < PTS; g++) begin : g_pt
            assign fmask[g] = frc_q[g].on;
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    last_q[g] <= 16'h0000;
                    pt_out_q[g] <= 16'h0000;
                    pt_in_q[g] <= 16'h0000;
                end else begin
                    if (frc_q[g].on) begin
                        last_q[g] <= frc_q[g].value; // see RULE20
                        pt_out_q[g] <= frc_q[g].value; // see RULE13 see RULE19
                        pt_in_q[g] <= frc_q[g].value;
                    end else begin
                        if (host_out_valid) begin
                            last_q[g] <= host_out[g];
                            pt_out_q[g] <= host_out[g]; // see RULE17
                        end else begin
                            pt_out_q[g] <= hold_q[g] ? last_q[g] : 16'h0000;
                        end
                        pt_in_q[g] <= field_in[g];
                    end
                end
            end
        end
    endgenerate
    assign pt_out = pt_out_q;
    assign pt_in = pt_in_q;
    assign any_forced = |fmask;

    ftf_blink #(.HALF_CYC(BLINK_HALF)) u_blink (
        .aclk(aclk),
        .aresetn(aresetn),
        .active(any_forced), // see RULE16
        .led_q(led_io_en)
    );

    // ------------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------------
    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready = !w_have_q;
    assign wr_go = aw_have_q && w_have_q && !bvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bresp_q <= RSP_OK;
            sel_q <= 5'h00;
            map_q <= MAP_RST;
            hold_q <= HOLD_RST;
            clr_sw_q <= 1'b0;
            rej_q <= 1'b0;
            bus_req_q <= '0;
        end else begin
            clr_sw_q <= 1'b0;
            if (bus_take) begin
                bus_req_q.valid <= 1'b0;
            end
            if (s_axi_awvalid && !aw_have_q) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_have_q) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= RSP_OK;
                case (awaddr_q)
                    A_CTRL: clr_sw_q <= wstrb_q[0] & wdata_q[CTRL_CLR];
                    A_STATUS: ;
                    A_SEL: sel_q <= 5'(mrg({27'h0, sel_q}, wdata_q, wstrb_q));
                    A_MAP: map_q <= 5'(mrg({27'h0, map_q}, wdata_q, wstrb_q));
                    A_HOLD: hold_q <= 16'(mrg({16'h0, hold_q}, wdata_q, wstrb_q));
                    A_FCMD: begin
                        bus_req_q.valid <= 1'b1; // see RULE15
                        bus_req_q.unforce <= wdata_q[FC_UNF];
                        bus_req_q.idx <= wdata_q[FC_IDX +: 4];
                        bus_req_q.slot <= wdata_q[FC_SLOT +: 3];
                        bus_req_q.value <= wdata_q[15:0];
                    end
                    A_FDATA, A_FMASK: ;
                    default: bresp_q <= RSP_ERR;
                endcase
            end
            // A rejection in the same cycle as its clear keeps the flag set.
            if (wr_go && awaddr_q == A_STATUS && wstrb_q[2] && wdata_q[ST_REJ]) begin
                rej_q <= 1'b0;
            end
            if (rej_evt) begin
                rej_q <= 1'b1; // see RULE14
            end
        end
    end
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // ------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------
    assign s_axi_arready = !rvalid_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RSP_OK;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q <= RSP_OK;
            rdata_q <= 32'h0000_0000;
            case (s_axi_araddr)
                A_CTRL: ;
                A_STATUS: begin
                    rdata_q[4:0] <= fix_cnt_q;
                    rdata_q[12:8] <= ff_cnt_q;
                    rdata_q[ST_EMPTY] <= (fix_cnt_q == 5'h00); // see RULE7
                    rdata_q[ST_FORCED] <= any_forced;
                    rdata_q[ST_REJ] <= rej_q;
                    rdata_q[ST_SEEN] <= host_seen_q;
                end
                A_SEL: rdata_q[4:0] <= sel_q;
                A_FDATA: rdata_q <= {15'h0, rd_pres, 2'h0, rd_pres ? rd_ent : 14'h0};
                A_FCMD: ;
                A_MAP: rdata_q[4:0] <= map_q;
                A_HOLD: rdata_q[15:0] <= hold_q;
                A_FMASK: rdata_q[15:0] <= fmask;
                default: rresp_q <= RSP_ERR;
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_fix_full_ins;
        ins && !clr && fix_cnt_q == 5'(FIX_N);
    endsequence
    sequence s_queue_full_ins;
        s_fix_full_ins ##0 ff_cnt_q == 5'(FIFO_N);
    endsequence

    chk_table_bound: assert property (fix_cnt_q + ff_cnt_q <= 6'(TOT_N)) // see RULE1
        else $error("fault table holds more than its capacity");
    chk_fixed_kept: assert property (s_fix_full_ins |=> $stable(fix_q[0]) && fix_cnt_q == 5'(FIX_N)) // see RULE3
        else $error("fixed fault entry disturbed by overflow");
    chk_queue_drop: assert property (s_queue_full_ins |=> ff_cnt_q == 5'(FIFO_N) && ff_old == $past(ff_old) + 4'h1) // see RULE4
        else $error("queue overflow did not drop the oldest entry");
    chk_clear_empty: assert property (clr |=> fix_cnt_q == 5'h00 && ff_cnt_q == 5'h00) // see RULE9
        else $error("clear left entries in the table");
    chk_diag_rearm: assert property (clr && diag_lvl[0] |=> diag_pend_q[0]) // see RULE9
        else $error("persisting diagnostic not re-armed after clear");
    chk_force_wins: assert property (frc_q[5].on |=> pt_out_q[5] == $past(frc_q[5].value) // see RULE19
        && pt_in_q[5] == $past(frc_q[5].value))
        else $error("forced point did not take its forced value");
    chk_map_reject: assert property (rej_evt |=> rej_q && frc_q == $past(frc_q)) // see RULE14
        else $error("force outside the map was not rejected");
    chk_module_del: assert property (st_q == ST_RUN && cfg_del_valid && frc_q[2].slot == cfg_del_slot // see RULE18
        && !(req.valid && req_ok && req.idx == 4'h2) |=> !frc_q[2].on)
        else $error("force survived deletion of its module");
    chk_led_steady: assert property (!any_forced [*2] |=> led_io_en) // see RULE16
        else $error("indicator not steady with nothing forced");
    chk_unforced_follow: assert property (!frc_q[0].on && host_out_valid |=> pt_out_q[0] == $past(host_out[0])) // see RULE17
        else $error("unforced output did not follow host outputs");
endmodule

// *** tb_ftf_top.sv ***
// Self-checking bench for the fault table and force control block.
`timescale 1ns/1ps
module tb_ftf_top import ftf_pkg::*; ;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, flt_valid = 0;
    logic s_axi_bready = 1, s_axi_rready = 1, clr_cmd = 0, cfg_del_valid = 0, handheld_terminal_clear = 0, l;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, flt_ready, nv_save, led_io_en;
    logic host_clear, host_out_valid;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [DIAG_N-1:0] diag_lvl = 0;
    logic [2:0] cfg_del_slot = 0;
    ftf_fault_t flt_data = '0;
    ftf_force_req_t handheld_terminal_req = '0;
    ftf_force_ent_t [PTS-1:0] nv_image_i, nv_image_o;
    logic [PTS-1:0][15:0] host_out, field_in, pt_out, pt_in;
    int errors = 0, checks = 0, n;
    ftf_top #(.BLINK_HALF(4)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flt_valid,
        .flt_data, .flt_ready, .diag_lvl, .host_clear, .handheld_terminal_clear, .handheld_terminal_req,
        .cfg_del_valid, .cfg_del_slot, .nv_image_i, .nv_image_o, .nv_save, .host_out_valid, .host_out,
        .field_in, .pt_out, .pt_in, .led_io_en);
    ftf_host u_host (.aclk, .aresetn, .clr_cmd, .host_clear, .host_out_valid, .host_out);
    // ----------------------------------------------------------------
    // Bus tasks
    // ----------------------------------------------------------------
    function automatic logic [13:0] flt(input int i);
        return {CLS_MODULE, 3'h1, 5'(i), 4'h1};
    endfunction
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s exp %h seen %h", s, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Valids are dropped only at the edge that takes them, so no signal is assigned twice in a step.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        rs = s_axi_rresp;
    endtask
    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial forever #2.5 aclk = ~aclk;
    initial begin
        repeat (5000) @(posedge aclk);
        errors++;
        close_out;
    end
    initial begin
        nv_image_i = '0;
        nv_image_i[5] = '{1'b1, 3'h3, 16'h7777};
        for (int p = 0; p < PTS; p++) field_in[p] = 16'hC300 + 16'(p);
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(A_STATUS); chk("empty", d & 32'h9001F, 32'h90000);
        rd(A_MAP); chk("map", d, 32'h10);
        rd(A_HOLD); chk("hold", d, 32'h0);
        rd(8'h40); chk("unmapped", rs, RSP_ERR);
        wr(8'h40, 32'h0); chk("bad_wr", rs, RSP_ERR);
        chk("nv_force", pt_out[5], 16'h7777);
        flt_valid <= 1'b1;
        for (int i = 1; i <= 33; i++) begin
            flt_data <= flt(i);
            do @(posedge aclk); while (flt_ready !== 1'b1);
        end
        flt_valid <= 1'b0;
        rd(A_STATUS); chk("counts", d & 32'h11F1F, 32'h1010);
        wr(A_SEL, 32'h0); rd(A_FDATA); chk("first", d, 32'h10000 | flt(1));
        wr(A_SEL, 32'h10); rd(A_FDATA); chk("oldest", d, 32'h10000 | flt(18));
        diag_lvl <= 6'h05;
        repeat (3) @(posedge aclk);
        wr(A_SEL, 32'h1F); rd(A_FDATA); chk("diag", d & 32'h13E0F, 32'h13002);
        clr_cmd <= 1'b1;
        @(posedge aclk);
        clr_cmd <= 1'b0;
        repeat (3) @(posedge aclk);
        rd(A_STATUS); chk("cleared", d & 32'h11F1F, 32'h2);
        wr(A_SEL, 32'h0); rd(A_FDATA); chk("again", d, 32'h13000);
        wr(A_FCMD, 32'h00121234);
        repeat (3) @(posedge aclk);
        rd(A_FMASK); chk("fmask", d, 32'h24);
        chk("frc_out", pt_out[2], 16'h1234);
        chk("frc_in", pt_in[2], 16'h1234);
        chk("free_in", pt_in[4], 16'hC304);
        chk("nv_img", nv_image_o[2], {1'b1, 3'h1, 16'h1234});
        wr(A_MAP, 32'h2); wr(A_FCMD, 32'h00150001);
        repeat (3) @(posedge aclk);
        rd(A_STATUS); chk("reject", d[ST_REJ], 1'b1);
        wr(A_MAP, 32'h10);
        handheld_terminal_req <= '{1'b1, 1'b0, 4'h3, 3'h2, 16'h0ABC};
        @(posedge aclk);
        handheld_terminal_req <= '0;
        @(posedge aclk);
        chk("nv_save", nv_save, 1'b1);
        repeat (2) @(posedge aclk);
        chk("hh_force", pt_out[3], 16'h0ABC);
        n = 0;
        repeat (16) begin
            l = led_io_en;
            @(posedge aclk);
            n += (led_io_en !== l);
        end
        chk("blink", n, 4);
        cfg_del_slot <= 3'h1;
        cfg_del_valid <= 1'b1;
        @(posedge aclk);
        cfg_del_valid <= 1'b0;
        repeat (3) @(posedge aclk);
        rd(A_FMASK); chk("deleted", d, 32'h28);
        wr(A_FCMD, 32'h01030000);
        wr(A_FCMD, 32'h01050000);
        repeat (3) @(posedge aclk);
        chk("follow", pt_out[3], 16'h5A03);
        chk("steady", led_io_en, 1'b1);
        close_out;
    end
endmodule
